// >>> verilog/bsc_params.svh
// Constants for the bit set/clear and compare-skip execution block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

// Register byte offsets on the APB slave.
`define OFF_INSTR       8'h00
`define OFF_ACC         8'h04
`define OFF_FLAGS       8'h08
`define OFF_STATUS      8'h0C
`define OFF_IO_BASE     8'h40
`define OFF_MEM_BASE    8'h80

// Instruction word fields.
`define INSTR_OP_MSB    15
`define INSTR_OP_LSB    12
`define INSTR_BIT_MSB   10
`define INSTR_BIT_LSB   8
`define INSTR_ARG_MSB   7
`define INSTR_ARG_LSB   0

// Status register bit positions.
`define STATUS_SKIP_BIT    0
`define STATUS_EQUAL_BIT   1
`define STATUS_DROPPED_BIT 2

// Reset values.
`define RST_INSTR       16'h0000
`define RST_ACC         8'h00
`define RST_FLAGS       4'h0
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000

// Default sizes.
`define IO_PORTS_DEF    4
`define MEM_DEPTH_DEF   16

`endif

// >>> verilog/bsc_pkg.sv
// Types shared by the execution block and its helper units.
// Assumes nothing beyond a SystemVerilog compiler.
package bsc_pkg;

    typedef enum logic [3:0] {
        OP_NOP          = 4'h0,
        OP_IO_BIT_CLEAR  = 4'h1,
        OP_IO_BIT_SET    = 4'h2,
        OP_MEM_BIT_CLEAR = 4'h3,
        OP_MEM_BIT_SET   = 4'h4,
        OP_CMP_IMM       = 4'h5,
        OP_CMP_MEM       = 4'h6
    } op_t;

    typedef struct packed {
        logic overflowFlag;
        logic halfCarryFlag;
        logic carryFlag;
        logic zeroFlag;
    } flags_t;

    typedef enum logic {
        ST_IDLE    = 1'b0,
        ST_EXECUTE = 1'b1
    } fsm_t;

endpackage : bsc_pkg

// >>> verilog/operand_if.sv
// Operand and result bundle between the core and its two datapath units.
// Assumes the core drives operands and the units answer combinationally.
`timescale 1ns/1ps
interface operand_if;
    import bsc_pkg::*;
    logic   [7:0] opA;
    logic   [7:0] opB;
    logic   [2:0] bitIdx;
    logic         bitVal;
    logic   [7:0] modByte;
    flags_t       diffFlags;
    logic         equal;

    modport core (output opA, opB, bitIdx, bitVal, input modByte, diffFlags, equal);
    modport bitm (input opB, bitIdx, bitVal, output modByte);
    modport cmp  (input opA, opB, output diffFlags, equal);
endinterface : operand_if

// >>> verilog/bit_modify_unit.sv
// Single-bit force of a byte to 0 or 1.
// Assumes operands are stable for the whole cycle; purely combinational.
`timescale 1ns/1ps
module bit_modify_unit (
    operand_if.bitm ops     // operand bundle
);
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign ops.modByte[i] = (ops.bitIdx == 3'(i)) ? ops.bitVal : ops.opB[i];
        end
    endgenerate
endmodule : bit_modify_unit

// >>> verilog/subtract_compare_unit.sv
// Subtraction flags and equality of two bytes, result itself discarded.
// Assumes carry means borrow, as a subtract of opB from opA yields.
`timescale 1ns/1ps
module subtract_compare_unit (
    operand_if.cmp ops      // operand bundle
);
    logic [8:0] diff;
    logic [4:0] lowDiff;

    assign diff    = {1'b0, ops.opA} - {1'b0, ops.opB};
    assign lowDiff = {1'b0, ops.opA[3:0]} - {1'b0, ops.opB[3:0]};

    assign ops.diffFlags.zeroFlag      = (diff[7:0] == 8'h00);
    assign ops.diffFlags.carryFlag     = diff[8];
    assign ops.diffFlags.halfCarryFlag = lowDiff[4];
    assign ops.diffFlags.overflowFlag  = (ops.opA[7] ^ ops.opB[7]) & (ops.opA[7] ^ diff[7]);
    assign ops.equal                   = (ops.opA == ops.opB);
endmodule : subtract_compare_unit

// >>> verilog/bit_set_compare_skip.sv
// Execution core for single-bit set/clear and compare-and-skip instructions.
// Assumes an APB master on clk_sys; instructions arrive by writes to the
// instruction register, and the word written next after a skip is dropped.
//
// Contract
// - An IO bit-clear forces the chosen bit of the chosen IO port to 0, other bits kept.
// - An IO bit-set forces the chosen bit of the chosen IO port to 1, other bits kept.
// - A memory bit-clear writes 0 to the chosen bit of the memory byte, seven bits kept.
// - A memory bit-set writes 1 to the chosen bit of the memory byte, seven bits kept.
// - The four bit set/clear instructions leave all four arithmetic flags alone.
// - Compare-immediate skips the next instruction when the accumulator equals the byte.
// - Compare-immediate sets the flags as accumulator minus immediate would.
// - Compare-memory skips the next instruction when the accumulator equals the byte.
// - Compare-memory sets the flags as accumulator minus memory byte would.
// - Both compares update zero, carry, half-carry and overflow together.
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "bsc_params.svh"
module bit_set_compare_skip import bsc_pkg::*; #(
    parameter int IO_PORTS  = `IO_PORTS_DEF,
    parameter int MEM_DEPTH = `MEM_DEPTH_DEF
) (
    input  wire logic                  clk_sys,     // system clock, 20 MHz
    input  wire logic                  reset_n,     // asynchronous reset, active low
    input  wire logic                  psel,        // APB select
    input  wire logic                  penable,     // APB enable
    input  wire logic                  pwrite,      // APB write
    input  wire logic [7:0]            paddr,       // APB byte address
    input  wire logic [31:0]           pwdata,      // APB write data
    output logic      [31:0]           prdata,      // APB read data
    output logic                       pready,      // APB ready
    output logic                       pslverr,     // APB error, unmapped or misaligned address
    output logic      [IO_PORTS*8-1:0] ioPorts,     // IO port registers, port 0 lowest
    output logic                       skipPending  // next instruction will be dropped
);
    localparam int IO_IDX_W  = (IO_PORTS  > 1) ? $clog2(IO_PORTS)  : 1;
    localparam int MEM_IDX_W = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
    localparam logic [7:0] IO_END  = 8'(`OFF_IO_BASE + 4 * IO_PORTS);
    localparam logic [7:0] MEM_END = 8'(`OFF_MEM_BASE + 4 * MEM_DEPTH);

    typedef struct packed {
        fsm_t                          state;
        logic [15:0]                   instr;
        logic [7:0]                    acc;
        flags_t                        flags;
        logic                          skip;
        logic                          lastEqual;
        logic                          lastDropped;
        logic [IO_PORTS-1:0][7:0]      io;
        logic [MEM_DEPTH-1:0][7:0]     mem;
        logic                          pready;
        logic                          pslverr;
        logic [31:0]                   prdata;
    } state_t;

    state_t                st_reg;
    state_t                st_next;

    operand_if             ops ();

    op_t                   execOp;
    logic [2:0]            bitIdx;
    logic [7:0]            argByte;
    logic [IO_IDX_W-1:0]   ioIdx;
    logic [MEM_IDX_W-1:0]  memIdx;
    logic                  inIo;
    logic                  inMem;
    logic                  hit;
    logic [IO_IDX_W-1:0]   apbIoIdx;
    logic [MEM_IDX_W-1:0]  apbMemIdx;
    logic [31:0]           readMux;
    logic                  xfer;
    logic                  execLive;

    bit_modify_unit u_bit (
        .ops (ops.bitm)
    );

    subtract_compare_unit u_cmp (
        .ops (ops.cmp)
    );

    // Decode of the latched instruction word.
    assign execOp   = op_t'(st_reg.instr[`INSTR_OP_MSB:`INSTR_OP_LSB]);
    assign bitIdx   = st_reg.instr[`INSTR_BIT_MSB:`INSTR_BIT_LSB];
    assign argByte  = st_reg.instr[`INSTR_ARG_MSB:`INSTR_ARG_LSB];
    assign ioIdx    = argByte[IO_IDX_W-1:0];
    assign memIdx   = argByte[MEM_IDX_W-1:0];
    assign execLive = (st_reg.state == ST_EXECUTE) && !st_reg.skip;

    // Operands for the datapath units: IO ops take the port byte, memory ops
    // and the memory compare take the memory byte, otherwise the immediate.
    assign ops.opA    = st_reg.acc;
    assign ops.bitIdx = bitIdx;
    assign ops.bitVal = (execOp == OP_IO_BIT_SET) || (execOp == OP_MEM_BIT_SET);
    always_comb begin
        case (execOp)
            OP_IO_BIT_CLEAR, OP_IO_BIT_SET: begin
                ops.opB = st_reg.io[ioIdx];
            end
            OP_MEM_BIT_CLEAR, OP_MEM_BIT_SET, OP_CMP_MEM: begin
                ops.opB = st_reg.mem[memIdx];
            end
            default: begin
                ops.opB = argByte;
            end
        endcase
    end

    // APB address decode; anything misaligned or outside the map answers an error.
    assign inIo      = (paddr >= `OFF_IO_BASE) && (paddr < IO_END);
    assign inMem     = (paddr >= `OFF_MEM_BASE) && (paddr < MEM_END);
    assign apbIoIdx  = IO_IDX_W'((paddr - `OFF_IO_BASE) >> 2);
    assign apbMemIdx = MEM_IDX_W'((paddr - `OFF_MEM_BASE) >> 2);
    assign hit       = (paddr[1:0] == 2'b00) &&
                       (inIo || inMem || paddr == `OFF_INSTR || paddr == `OFF_ACC ||
                        paddr == `OFF_FLAGS || paddr == `OFF_STATUS);
    assign xfer      = psel && penable && st_reg.pready;

    always_comb begin
        readMux = `RST_WORD;
        if (inIo) begin
            readMux[7:0] = st_reg.io[apbIoIdx];
        end else if (inMem) begin
            readMux[7:0] = st_reg.mem[apbMemIdx];
        end else begin
            case (paddr)
                `OFF_INSTR:  readMux[15:0] = st_reg.instr;
                `OFF_ACC:    readMux[7:0]  = st_reg.acc;
                `OFF_FLAGS:  readMux[3:0]  = st_reg.flags;
                `OFF_STATUS: begin
                    readMux[`STATUS_SKIP_BIT]    = st_reg.skip;
                    readMux[`STATUS_EQUAL_BIT]   = st_reg.lastEqual;
                    readMux[`STATUS_DROPPED_BIT] = st_reg.lastDropped;
                end
                default:     readMux = `RST_WORD;
            endcase
        end
    end

    always_comb begin
        st_next         = st_reg;
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;

        // Ready is held back while an instruction executes, so a bus write can
        // never collide with the execution write of the same cycle.
        if (psel && penable && !st_reg.pready && st_reg.state == ST_IDLE) begin
            st_next.pready  = 1'b1;
            st_next.pslverr = !hit;
            st_next.prdata  = (hit && !pwrite) ? readMux : `RST_WORD;
        end

        if (xfer && pwrite && hit) begin
            if (inIo) begin
                st_next.io[apbIoIdx] = pwdata[7:0];
            end else if (inMem) begin
                st_next.mem[apbMemIdx] = pwdata[7:0];
            end else begin
                case (paddr)
                    `OFF_INSTR: begin
                        st_next.instr = pwdata[15:0];
                        st_next.state = ST_EXECUTE;
                    end
                    `OFF_ACC:   st_next.acc   = pwdata[7:0];
                    `OFF_FLAGS: st_next.flags = flags_t'(pwdata[3:0]);
                    default:    ;
                endcase
            end
        end

        case (st_reg.state)
            ST_IDLE: begin
            end
            ST_EXECUTE: begin
                st_next.state = ST_IDLE;
                if (st_reg.skip) begin
                    // The dropped word only consumes the pending skip and sets the dropped status bit.
                    st_next.skip        = 1'b0;
                    st_next.lastDropped = 1'b1;
                end else begin
                    st_next.lastDropped = 1'b0;
                    case (execOp)
                        OP_IO_BIT_CLEAR, OP_IO_BIT_SET: begin
                            st_next.io[ioIdx] = ops.modByte;
                        end
                        OP_MEM_BIT_CLEAR, OP_MEM_BIT_SET: begin
                            st_next.mem[memIdx] = ops.modByte;
                        end
                        OP_CMP_IMM, OP_CMP_MEM: begin
                            // Accumulator and memory are left untouched here.
                            st_next.flags     = ops.diffFlags;
                            st_next.skip      = ops.equal;
                            st_next.lastEqual = ops.equal;
                        end
                        default: ;
                    endcase
                end
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_reg.state       <= ST_IDLE;
            st_reg.instr       <= `RST_INSTR;
            st_reg.acc         <= `RST_ACC;
            st_reg.flags       <= `RST_FLAGS;
            st_reg.skip        <= 1'b0;
            st_reg.lastEqual   <= 1'b0;
            st_reg.lastDropped <= 1'b0;
            st_reg.io          <= '0;
            st_reg.mem         <= '0;
            st_reg.pready      <= 1'b0;
            st_reg.pslverr     <= 1'b0;
            st_reg.prdata      <= `RST_WORD;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata      = st_reg.prdata;
    assign pready      = st_reg.pready;
    assign pslverr     = st_reg.pslverr;
    assign ioPorts     = st_reg.io;
    assign skipPending = st_reg.skip;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_exec(logic [3:0] o);
        execLive && (execOp == o);
    endsequence

    sequence s_compare;
        execLive && (execOp == OP_CMP_IMM || execOp == OP_CMP_MEM);
    endsequence

    sequence s_skipped;
        (st_reg.state == ST_EXECUTE) && st_reg.skip;
    endsequence

    chk_io_clear_bit: assert property (
        s_exec(OP_IO_BIT_CLEAR) |=> st_reg.io[$past(ioIdx)] ==
            ($past(st_reg.io[ioIdx]) & ~(8'h01 << $past(bitIdx))))
        else $error("IO bit clear gave a wrong port byte");

    chk_io_set_bit: assert property (
        s_exec(OP_IO_BIT_SET) |=> st_reg.io[$past(ioIdx)] ==
            ($past(st_reg.io[ioIdx]) | (8'h01 << $past(bitIdx))))
        else $error("IO bit set gave a wrong port byte");

    chk_mem_clear_bit: assert property (
        s_exec(OP_MEM_BIT_CLEAR) |=> st_reg.mem[$past(memIdx)] ==
            ($past(st_reg.mem[memIdx]) & ~(8'h01 << $past(bitIdx))))
        else $error("Memory bit clear gave a wrong byte");

    chk_mem_set_bit: assert property (
        s_exec(OP_MEM_BIT_SET) |=> st_reg.mem[$past(memIdx)] ==
            ($past(st_reg.mem[memIdx]) | (8'h01 << $past(bitIdx))))
        else $error("Memory bit set gave a wrong byte");

    chk_bitop_flags_kept: assert property (
        (execLive && execOp inside {OP_IO_BIT_CLEAR, OP_IO_BIT_SET,
                                    OP_MEM_BIT_CLEAR, OP_MEM_BIT_SET})
        |=> $stable(st_reg.flags) && !st_reg.skip)
        else $error("Bit set or clear disturbed the flags");

    chk_cmp_imm_skip: assert property (
        s_exec(OP_CMP_IMM) |=> st_reg.skip == ($past(st_reg.acc) == $past(argByte)))
        else $error("Immediate compare skip decision wrong");

    chk_cmp_imm_flags: assert property (
        s_exec(OP_CMP_IMM) |=>
            st_reg.flags.zeroFlag == ($past(st_reg.acc) == $past(argByte)) &&
            st_reg.flags.carryFlag == ($past(st_reg.acc) < $past(argByte)))
        else $error("Immediate compare zero or carry wrong");

    chk_cmp_mem_skip: assert property (
        s_exec(OP_CMP_MEM) ##1 st_reg.skip |=> s_skipped or (st_reg.state == ST_IDLE))
        else $error("Memory compare skip not held for the next word");

    chk_cmp_mem_flags: assert property (
        s_exec(OP_CMP_MEM) |=>
            st_reg.flags.halfCarryFlag ==
                ($past(st_reg.acc[3:0]) < $past(st_reg.mem[memIdx][3:0])) &&
            st_reg.skip == ($past(st_reg.acc) == $past(st_reg.mem[memIdx])))
        else $error("Memory compare half carry or skip wrong");

    chk_cmp_overflow: assert property (
        s_compare |=> st_reg.flags.overflowFlag ==
            (($past(ops.opA[7]) ^ $past(ops.opB[7])) &
             ($past(ops.opA[7]) ^ ($past(ops.opA) - $past(ops.opB)) >> 7 & 8'h01) != 0))
        else $error("Compare overflow flag wrong");

    chk_cmp_keeps_data: assert property (
        s_compare |=> $stable(st_reg.acc) && $stable(st_reg.mem) && $stable(st_reg.io))
        else $error("Compare altered accumulator or memory");

    chk_skipped_noop: assert property (
        s_skipped |=> $stable(st_reg.io) && $stable(st_reg.mem) && $stable(st_reg.acc) &&
            $stable(st_reg.flags) && !st_reg.skip && st_reg.lastDropped)
        else $error("Skipped instruction had an effect");

    chk_ready_idle_only: assert property (
        $rose(st_reg.pready) |-> $past(st_reg.state) == ST_IDLE ##1 !st_reg.pready)
        else $error("Ready raised during execution or held too long");

    chk_cmp_imm_half: assert property (
        s_exec(OP_CMP_IMM) |=>
            st_reg.flags.halfCarryFlag == ($past(st_reg.acc[3:0]) < $past(argByte[3:0])))
        else $error("Immediate compare half carry wrong");

    chk_cmp_mem_zero: assert property (
        s_exec(OP_CMP_MEM) |=>
            st_reg.flags.zeroFlag == ($past(st_reg.acc) == $past(st_reg.mem[memIdx])) &&
            st_reg.flags.carryFlag == ($past(st_reg.acc) < $past(st_reg.mem[memIdx])))
        else $error("Memory compare zero or carry wrong");

    chk_equal_status: assert property (
        s_compare |=> st_reg.lastEqual == st_reg.skip && !st_reg.lastDropped)
        else $error("Compare status bits disagree with the skip");

    chk_io_op_keeps_mem: assert property (
        (execLive && execOp inside {OP_IO_BIT_CLEAR, OP_IO_BIT_SET})
        |=> $stable(st_reg.mem) && $stable(st_reg.acc))
        else $error("IO bit operation touched memory or accumulator");

    chk_mem_op_keeps_io: assert property (
        (execLive && execOp inside {OP_MEM_BIT_CLEAR, OP_MEM_BIT_SET})
        |=> $stable(st_reg.io) && $stable(st_reg.acc))
        else $error("Memory bit operation touched ports or accumulator");

    chk_drop_keeps_equal: assert property (
        s_skipped |=> $stable(st_reg.lastEqual) && (st_reg.state == ST_IDLE))
        else $error("Dropped word changed the compare status");

    // A bus write landing in the execute cycle would race the execution write.
    chk_exec_bus_quiet: assert property (
        (st_reg.state == ST_EXECUTE) |-> !xfer && !st_reg.pready)
        else $error("Bus transfer completed during execution");

    chk_exec_one_cycle: assert property (
        (st_reg.state == ST_EXECUTE) |=> (st_reg.state == ST_IDLE))
        else $error("Execution lasted more than one cycle");

    chk_error_with_ready: assert property (
        st_reg.pslverr |-> st_reg.pready && st_reg.prdata == `RST_WORD)
        else $error("Error answer without ready or with data");

endmodule : bit_set_compare_skip

// >>> dv/test_bit_set_compare_skip.sv
// Self-checking bench for the bit set/clear and compare-skip execution block.
// Assumes the block is the only APB slave on clk_sys and that it is reset at the start.
`timescale 1ns/1ps
`include "bsc_params.svh"
module test_bit_set_compare_skip import bsc_pkg::*;;

    logic        clk_sys;
    logic        reset_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] ioPorts;
    logic        skipPending;
    int          n_fail;
    int          checks;
    // Reference state, updated by the bench alongside every access it makes.
    logic [7:0]  ioM [4];
    logic [7:0]  memM [16];
    logic [7:0]  accM;
    logic [3:0]  flgM;
    logic        skipM;
    logic        eqM;
    logic        dropM;
    logic [7:0]  pairA [6] = '{8'h55, 8'h10, 8'h20, 8'h80, 8'h7F, 8'h00};
    logic [7:0]  pairB [6] = '{8'h55, 8'h20, 8'h01, 8'h01, 8'hFF, 8'h00};
    op_t         bitOps [4] = '{OP_IO_BIT_CLEAR, OP_IO_BIT_SET, OP_MEM_BIT_CLEAR, OP_MEM_BIT_SET};

    bit_set_compare_skip #(.IO_PORTS(4), .MEM_DEPTH(16)) i_dut (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .ioPorts     (ioPorts),
        .skipPending (skipPending)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Flags of a - b in register order: overflow, half borrow, borrow, zero.
    function automatic logic [3:0] subFlags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {(a[7] != b[7]) && (d[7] != a[7]), a[3:0] < b[3:0], a < b, a == b};
    endfunction : subFlags

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One APB transfer; entered just after a rising edge, leaves just after one.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // No wait limit here: a slave that never answers is caught by the watchdog.
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(a, 1'b1, d, r, e);
    endtask : wr

    task automatic rdExp(input logic [7:0] a, input logic [31:0] exp, input logic expErr,
                         input string what);
        logic [31:0] r;
        logic        e;
        xfer(a, 1'b0, 32'h0000_0000, r, e);
        chk(what, exp, r);
        chk("pslverr", {31'h0, expErr}, {31'h0, e});
    endtask : rdExp

    // Issues one instruction and mirrors its effect, or its dropping, in the model.
    task automatic exec(input op_t op, input logic [2:0] b, input logic [7:0] arg);
        wr(`OFF_INSTR, {16'h0000, op, 1'b0, b, arg});
        if (skipM) begin
            skipM = 1'b0;
            dropM = 1'b1;
        end else begin
            dropM = 1'b0;
            case (op)
                OP_IO_BIT_CLEAR:  ioM[arg[1:0]][b] = 1'b0;
                OP_IO_BIT_SET:    ioM[arg[1:0]][b] = 1'b1;
                OP_MEM_BIT_CLEAR: memM[arg[3:0]][b] = 1'b0;
                OP_MEM_BIT_SET:   memM[arg[3:0]][b] = 1'b1;
                OP_CMP_IMM: begin
                    flgM  = subFlags(accM, arg);
                    skipM = (accM == arg);
                    eqM   = skipM;
                end
                OP_CMP_MEM: begin
                    flgM  = subFlags(accM, memM[arg[3:0]]);
                    skipM = (accM == memM[arg[3:0]]);
                    eqM   = skipM;
                end
                default: ;
            endcase
        end
    endtask : exec

    task automatic checkAll();
        rdExp(`OFF_ACC, {24'h0, accM}, 1'b0, "acc");
        rdExp(`OFF_FLAGS, {28'h0, flgM}, 1'b0, "flags");
        rdExp(`OFF_STATUS, {29'h0, dropM, eqM, skipM}, 1'b0, "status");
        for (int i = 0; i < 4; i++) begin
            rdExp(8'(`OFF_IO_BASE + 4 * i), {24'h0, ioM[i]}, 1'b0, "io byte");
        end
        for (int j = 0; j < 16; j++) begin
            rdExp(8'(`OFF_MEM_BASE + 4 * j), {24'h0, memM[j]}, 1'b0, "mem byte");
        end
        chk("ioPorts", {ioM[3], ioM[2], ioM[1], ioM[0]}, ioPorts);
        chk("skipPending", {31'h0, skipM}, {31'h0, skipPending});
    endtask : checkAll

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("ERROR watchdog expected finish seen hang");
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        n_fail  = 0;
        checks  = 0;
        reset_n = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        accM    = 8'h00;
        flgM    = 4'h0;
        skipM   = 1'b0;
        eqM     = 1'b0;
        dropM   = 1'b0;
        foreach (ioM[i]) ioM[i] = 8'h00;
        foreach (memM[j]) memM[j] = 8'h00;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        checkAll();
        $display("test reset done");

        // Flags preset to all ones so that any disturbance by a bit op shows.
        for (int i = 0; i < 4; i++) begin
            ioM[i] = 8'h5A ^ 8'(i * 17);
            wr(8'(`OFF_IO_BASE + 4 * i), {24'h0, ioM[i]});
        end
        for (int j = 0; j < 16; j++) begin
            memM[j] = 8'hA5 ^ 8'(j * 7);
            wr(8'(`OFF_MEM_BASE + 4 * j), {24'h0, memM[j]});
        end
        flgM = 4'hF;
        wr(`OFF_FLAGS, 32'h0000_000F);
        for (int b = 0; b < 8; b++) begin
            for (int o = 0; o < 4; o++) begin
                exec(bitOps[o], 3'(b), 8'(b * 5));
                checkAll();
            end
        end
        $display("test bit operations done");

        // Each compare is followed by a bit set or clear that must run or be dropped.
        for (int k = 0; k < 6; k++) begin
            accM = pairA[k];
            wr(`OFF_ACC, {24'h0, accM});
            exec(OP_CMP_IMM, 3'h0, pairB[k]);
            checkAll();
            exec(OP_IO_BIT_SET, 3'(k), 8'(k));
            checkAll();
        end
        $display("test compare immediate done");

        for (int k = 0; k < 6; k++) begin
            accM = pairA[k];
            memM[k + 8] = pairB[k];
            wr(`OFF_ACC, {24'h0, accM});
            wr(8'(`OFF_MEM_BASE + 4 * (k + 8)), {24'h0, pairB[k]});
            exec(OP_CMP_MEM, 3'h0, 8'(k + 8));
            checkAll();
            exec(OP_MEM_BIT_CLEAR, 3'(k), 8'(k + 8));
            checkAll();
        end
        $display("test compare memory done");

        // A compare that is itself dropped must not arm another skip.
        accM = 8'h33;
        wr(`OFF_ACC, 32'h0000_0033);
        exec(OP_CMP_IMM, 3'h0, 8'h33);
        exec(OP_CMP_IMM, 3'h0, 8'h33);
        checkAll();
        exec(OP_IO_BIT_CLEAR, 3'h1, 8'h02);
        checkAll();
        $display("test dropped compare done");

        // Refused accesses leave every register as it was.
        xfer(8'h20, 1'b0, 32'h0000_0000, r, e);
        chk("unmapped read", 32'h0000_0001, {31'h0, e});
        chk("unmapped data", 32'h0000_0000, r);
        xfer(8'h05, 1'b1, 32'h0000_00FF, r, e);
        chk("misaligned write", 32'h0000_0001, {31'h0, e});
        wr(`OFF_STATUS, 32'h0000_0007);
        checkAll();
        $display("test refused access done");
        end_of_test();
    end

endmodule : test_bit_set_compare_skip
